// ### testbench/sap_host.sv
/*
 * Host controller model on the shared address/data bus.
 * Assumes the bench calls its tasks; the bus clock runs only in phases.
 */
`timescale 1ns/10ps
`default_nettype none
module sap_host (
    input wire logic clk,
    input wire logic [sap_pkg::LO_W-1:0] dev_q,
    input wire logic dev_oe,
    output sap_pkg::sap_pins_s pins,
    output logic [sap_pkg::LO_W-1:0] wire_q
);
    import sap_pkg::*;
    logic [LO_W-1:0] drv_q;
    logic drv_on;
    // ********************
    // Bus wire and tasks
    // ********************
    // A released bus shows the inverse, so a stale value never passes
    assign wire_q = dev_oe ? dev_q : (drv_on ? drv_q : ~drv_q);
    // Idle: strobes high, bus clock still
    initial
    begin
        pins = 5'b11110;
        drv_q = 16'h0000;
        drv_on = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One address phase; the upper half goes with output-enable low
    task automatic addr(input logic [LO_W-1:0] a, input logic up,
        input logic sync);
        tick(1);
        pins.chip_en_n <= 1'b0;
        pins.out_en_n <= ~up;
        drv_q <= a;
        drv_on <= 1'b1;
        pins.address_valid_strobe_n <= 1'b0;
        tick(3);
        if (sync)
        begin
            pins.bus_clk <= 1'b1;
            tick(3);
            pins.bus_clk <= 1'b0;
        end
        else
            pins.address_valid_strobe_n <= 1'b1;
        tick(3);
    endtask
    // Output-enable falls only after strobe rise and address hold
    task automatic rd(output logic [LO_W-1:0] q);
        pins.address_valid_strobe_n <= 1'b1;
        drv_on <= 1'b0;
        tick(2);
        pins.out_en_n <= 1'b0;
        repeat (12)
        begin
            tick(1);
            #1;
            if (dev_oe === 1'b1)
                break;
        end
        q = wire_q;
    endtask
    // The write ends on the write-enable rise, bus clock untouched
    task automatic wr(input logic [LO_W-1:0] d);
        pins.address_valid_strobe_n <= 1'b1;
        drv_q <= d;
        drv_on <= 1'b1;
        tick(2);
        pins.write_en_n <= 1'b0;
        tick(3);
        pins.write_en_n <= 1'b1;
        tick(3);
    endtask
    // One bus clock period in the data phase of a burst
    task automatic burst_clk;
        tick(1);
        pins.bus_clk <= 1'b1;
        tick(3);
        pins.bus_clk <= 1'b0;
        tick(3);
        #1;
    endtask
    // Every cycle runs to its end, so no second early restart occurs
    task automatic done;
        tick(1);
        pins <= 5'b11110;
        drv_on <= 1'b0;
        tick(4);
    endtask
endmodule
`default_nettype wire

// ### testbench/tb_sap_port.sv
/*
 * Self-checking bench of the split-address bus port.
 * Assumes the host model sap_host and a 10 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) \
    begin \
        cmp_count++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("BAD %s exp %h got %h", n, e, g); \
        end \
    end
module tb_sap_port;
    import sap_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    sap_pins_s pins;
    logic [LO_W-1:0] adq_in, adq_out, array_rdata, array_wdata, wr_data;
    logic adq_oe, ready_out, ready_oe, array_wr;
    logic [RA_W-1:0] reg_addr = 2'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, rd_q;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [UP_W+LO_W-1:0] array_addr, wr_addr;
    int mismatches = 0, cmp_count = 0, wr_cnt = 0;
    // ********************
    // Clock, array, watchdog
    // ********************
    always #50 clk = ~clk;
    // Array word depends on both address halves
    assign array_rdata = array_addr[15:0] ^ {6'h00, array_addr[25:16]};
    always @(posedge clk)
        if (array_wr === 1'b1)
        begin
            wr_cnt <= wr_cnt + 1;
            wr_data <= array_wdata;
            wr_addr <= array_addr;
        end
    // The run needs well under 1000 cycles
    initial
    begin
        #(4000 * 100);
        mismatches++;
        report_and_stop;
    end
    sap_port u_sap_port (.clk(clk), .resetn(resetn), .pins(pins),
        .adq_in(adq_in), .adq_out(adq_out), .adq_oe(adq_oe),
        .ready_out(ready_out), .ready_oe(ready_oe), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .array_addr(array_addr),
        .array_rdata(array_rdata), .array_wr(array_wr),
        .array_wdata(array_wdata));
    sap_host u_sap_host (.clk(clk), .dev_q(adq_out), .dev_oe(adq_oe),
        .pins(pins), .wire_q(adq_in));
    task automatic reg_w(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic reg_r(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Full read cycle; eu is the upper half the port should use
    task automatic bus_read(input logic [9:0] up, input logic two,
        input logic [15:0] lo, input logic sync, input logic [9:0] eu,
        input logic er);
        logic [15:0] q;
        if (two)
            u_sap_host.addr({6'h00, up}, 1'b1, sync);
        u_sap_host.addr(lo, 1'b0, sync);
        u_sap_host.rd(q);
        `CHK("array_addr", {eu, lo}, array_addr)
        `CHK("read data", lo ^ {6'h00, eu}, q)
        `CHK("indicator level", er, ready_out)
        `CHK("indicator on", 1'b1, ready_oe)
        u_sap_host.done();
        #1;
        `CHK("indicator off", 1'b0, ready_oe)
    endtask
    task automatic t_reset;
        reg_r(OFF_RCR, rd_q);
        `CHK("config reset", 16'h8000, rd_q)
        `CHK("bus enable", 1'b0, adq_oe)
        reg_r(OFF_STATUS, rd_q);
        `CHK("status idle", 16'h0000, rd_q)
        $display("test reset done");
    endtask
    // Plain mode latches an upper phase as a lower half, which the real lower phase overwrites: upper lines count as grounded
    task automatic t_plain;
        bus_read(10'h155, 1'b1, 16'h4321, 1'b0, 10'h000, 1'b1);
        $display("test plain done");
    endtask
    task automatic t_entry;
        reg_w(OFF_RCR, 16'h8010);
        reg_r(OFF_RCR, rd_q);
        `CHK("config", 16'h8010, rd_q)
        bus_read(10'h3C3, 1'b0, 16'hBEEF, 1'b0, 10'h000, 1'b1);
        $display("test entry done");
    endtask
    task automatic t_async;
        bus_read(10'h2A5, 1'b1, 16'h1234, 1'b0, 10'h2A5, 1'b1);
        bus_read(10'h3FF, 1'b0, 16'h0F0F, 1'b0, 10'h2A5, 1'b1);
        bus_read(10'h001, 1'b0, 16'hF0F0, 1'b0, 10'h2A5, 1'b1);
        $display("test async done");
    endtask
    task automatic t_pol;
        reg_w(OFF_RCR, 16'h8510);
        bus_read(10'h07E, 1'b1, 16'h5555, 1'b0, 10'h07E, 1'b0);
        $display("test polarity done");
    endtask
    task automatic t_sync;
        reg_w(OFF_RCR, 16'h0010);
        bus_read(10'h11C, 1'b1, 16'h0042, 1'b1, 10'h11C, 1'b1);
        bus_read(10'h200, 1'b0, 16'h0043, 1'b1, 10'h11C, 1'b1);
        $display("test sync done");
    endtask
    // A burst step past a wordline end starts a fresh sense
    task automatic t_burst;
        u_sap_host.addr(16'h004E, 1'b0, 1'b1);
        u_sap_host.rd(rd_q);
        u_sap_host.burst_clk();
        `CHK("burst addr", {10'h11C, 16'h004F}, array_addr)
        u_sap_host.burst_clk();
        `CHK("wordline addr", {10'h11C, 16'h0050}, array_addr)
        `CHK("wordline data", 16'h0050 ^ 16'h011C, adq_in)
        `CHK("wordline ready", 1'b1, ready_out)
        u_sap_host.done();
        $display("test burst done");
    endtask
    task automatic t_write;
        int n0 = wr_cnt;
        u_sap_host.addr(16'h0777, 1'b0, 1'b1);
        u_sap_host.wr(16'hA5A5);
        u_sap_host.done();
        `CHK("write count", n0 + 1, wr_cnt)
        `CHK("write data", 16'hA5A5, wr_data)
        `CHK("write addr", {10'h11C, 16'h0777}, wr_addr)
        $display("test write done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        t_reset;
        t_plain;
        t_entry;
        t_async;
        t_pol;
        t_sync;
        t_burst;
        t_write;
        report_and_stop;
    end
endmodule
`default_nettype wire

// ### verilog/sap_pkg.sv
/*
 * Shared constants and types of the split-address bus port.
 * Assumes one 10 MHz core clock; host pins are synchronised inside the port.
 */
`default_nettype none
package sap_pkg;
    // ****************************************
    // Widths
    // ****************************************
    localparam int unsigned LO_W = 16;      // Lower address and data width
    localparam int unsigned UP_W = 10;      // Upper address width
    localparam int unsigned WL_W = 4;       // Words per wordline, as log2
    localparam int unsigned RA_W = 2;       // Register port address width

    // ****************************************
    // Register offsets, fields and reset values
    // ****************************************
    localparam logic [1:0] OFF_RCR = 2'h0;
    localparam logic [1:0] OFF_UPPER = 2'h1;
    localparam logic [1:0] OFF_LOWER = 2'h2;
    localparam logic [1:0] OFF_STATUS = 2'h3;
    localparam int unsigned BIT_MODE = 15;  // 0 = synchronous
    localparam int unsigned BIT_POL = 10;   // 1 = indicator active low
    localparam int unsigned BIT_TIM = 8;    // 0 = indicator with data
    localparam int unsigned BIT_SPLIT = 4;  // 1 = split-address mode
    localparam logic [15:0] RCR_RESET = 16'h8000;
    localparam logic [UP_W-1:0] UPPER_RESET = 10'h000;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_NS = 100;
    localparam int unsigned ACCESS_NS = 106;
    localparam int unsigned ACCESS_CYC =
        (ACCESS_NS / CLK_NS < 1) ? 1 : ACCESS_NS / CLK_NS;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic chip_en_n;
        logic out_en_n;
        logic write_en_n;
        logic address_valid_strobe_n;
        logic bus_clk;
    } sap_pins_s;

    typedef enum logic [1:0] {
        SAP_IDLE = 2'b00,
        SAP_UPPER = 2'b01,
        SAP_SENSE = 2'b10,
        SAP_DATA = 2'b11
    } sap_state_e;
endpackage
`default_nettype wire

// ### verilog/sap_port.sv
/*
 * Split-address multiplexed host bus port of a flash device.
 * Assumes host pins arrive asynchronously to clk and are synchronised
 * here; the host bus clock is sampled as a plain pin. The array sits
 * behind array_* with a fixed access time.
 */
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Synchronous mode allows one or two address cycles, like asynchronous.
// - Upper half comes first with output-enable low, lower with it high.
// - Single address cycle latches lower half, reuses last upper half.
// - Sync mode latches on bus clock edge; lower latch starts sensing.
// - Strobe may stay low; halves latch on consecutive bus clocks.
// - Async access counts from strobe rise, at most 106 ns; here done comes 2 clocks (200 ns) after sense start.
// - Sync writes latch address on clock, complete on write-enable rise.
// - Indicator polarity and timing follow two configuration bits.
// - Non-wrapping bursts may hold at wordline ends via indicator.
// - Upper address zero outside split mode; boot from bottom region.
// - Writing 1 to split bit enables split mode; reset default off.
// - Entering split mode clears the upper latch to zero.
// - In split mode indicator is driven exactly when data lines are.
// - Async: strobe rise with output-enable low upper, high lower.
module sap_port (
    input wire logic clk,
    input wire logic resetn,
    input wire sap_pkg::sap_pins_s pins,
    input wire logic [sap_pkg::LO_W-1:0] adq_in,
    output logic [sap_pkg::LO_W-1:0] adq_out,
    output logic adq_oe,
    output logic ready_out,
    output logic ready_oe,
    input wire logic [sap_pkg::RA_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    output logic [sap_pkg::UP_W+sap_pkg::LO_W-1:0] array_addr,
    input wire logic [sap_pkg::LO_W-1:0] array_rdata,
    output logic array_wr,
    output logic [sap_pkg::LO_W-1:0] array_wdata
);
    import sap_pkg::*;
    sap_pins_s pin_s;
    sap_pins_s pin_prev_ff;
    logic [LO_W-1:0] adq_s;
    logic [15:0] rcr_ff, nxt_rcr;
    logic [UP_W-1:0] upper_ff, nxt_upper;
    logic [LO_W-1:0] lower_ff, nxt_lower;
    sap_state_e state_ff, nxt_state;
    logic restart_ff, nxt_restart;
    logic viol_ff, nxt_viol;
    logic wr_ff, nxt_wr;
    logic [LO_W-1:0] wdata_ff, nxt_wdata;
    logic [15:0] rdata_ff, nxt_rdata;
    logic sync_mode, split_en, cap_evt, cap_up, cap_lo;
    logic wl_end, burst_step, sense_start;
    logic sense_busy, sense_done, drive, ready_lvl;
    logic [LO_W-1:0] sense_data;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    sap_sync #(.W($bits(sap_pins_s))) u_pin_sync (
        .clk(clk),
        .resetn(resetn),
        .d(pins),
        .rst_val('1),
        .q(pin_s)
    );
    // Bus is held stable around capture, so bit skew does no harm
    sap_sync #(.W(LO_W)) u_adq_sync (
        .clk(clk),
        .resetn(resetn),
        .d(adq_in),
        .rst_val('1),
        .q(adq_s)
    );
    // Previous synchronised levels for edge detection
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pin_prev_ff <= '1;
        else
            pin_prev_ff <= pin_s;
    end

    // ****************************************
    // Address capture events
    // ****************************************
    // Sync captures on a bus clock rise while the strobe is low,
    // so a strobe held low latches both halves on two clocks
    always_comb
    begin
        sync_mode = !rcr_ff[BIT_MODE];
        split_en = rcr_ff[BIT_SPLIT];
        if (sync_mode)
            cap_evt = pin_s.bus_clk && !pin_prev_ff.bus_clk &&
                !pin_s.address_valid_strobe_n;
        else
            cap_evt = pin_s.address_valid_strobe_n &&
                !pin_prev_ff.address_valid_strobe_n;
        cap_evt = cap_evt && !pin_s.chip_en_n;
        // Output-enable level tells the halves apart
        cap_up = cap_evt && split_en && !pin_s.out_en_n;
        cap_lo = cap_evt && !cap_up;
        burst_step = sync_mode && state_ff == SAP_DATA &&
            pin_s.bus_clk && !pin_prev_ff.bus_clk &&
            !pin_s.out_en_n && !cap_evt;
        wl_end = &lower_ff[WL_W-1:0];
        sense_start = cap_lo || (burst_step && wl_end);
    end

    // ****************************************
    // Bus cycle state and address latches
    // ****************************************
    always_comb
    begin
        nxt_state = state_ff;
        nxt_upper = upper_ff;
        nxt_lower = lower_ff;
        nxt_restart = restart_ff;
        // Clear first, so a host fault in the same cycle still sets it
        nxt_viol = viol_ff &&
            !(reg_wr && reg_addr == OFF_STATUS && reg_wdata[0]);
        case (state_ff)
            SAP_IDLE, SAP_UPPER, SAP_DATA:
            begin
                if (cap_up)
                    nxt_state = SAP_UPPER;
                else if (cap_lo)
                    nxt_state = SAP_SENSE;
                else if (burst_step && wl_end)
                    nxt_state = SAP_SENSE;
            end
            SAP_SENSE:
            begin
                if (cap_lo)
                begin
                    // Second early restart is a host fault; it still runs
                    nxt_viol = nxt_viol || restart_ff;
                    nxt_restart = 1'b1;
                end
                else if (cap_up)
                    nxt_state = SAP_UPPER;
                else if (sense_done)
                begin
                    nxt_state = SAP_DATA;
                    nxt_restart = 1'b0;
                end
            end
            default:
                nxt_state = SAP_IDLE;
        endcase
        if (cap_up)
            nxt_upper = adq_s[UP_W-1:0];
        if (cap_lo)
            nxt_lower = adq_s;
        else if (burst_step)
            nxt_lower = lower_ff + LO_W'(1);
        // Enabling split mode starts the upper latch at zero
        if (reg_wr && reg_addr == OFF_RCR &&
            reg_wdata[BIT_SPLIT] && !split_en)
            nxt_upper = UPPER_RESET;
        if (pin_s.chip_en_n && state_ff != SAP_SENSE)
            nxt_state = SAP_IDLE;
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= SAP_IDLE;
            upper_ff <= UPPER_RESET;
            lower_ff <= '0;
            restart_ff <= 1'b0;
            viol_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            upper_ff <= nxt_upper;
            lower_ff <= nxt_lower;
            restart_ff <= nxt_restart;
            viol_ff <= nxt_viol;
        end
    end
    // Outside split mode the upper lines are grounded
    assign array_addr = {split_en ? upper_ff : UPPER_RESET, lower_ff};

    // ****************************************
    // Array sensing
    // ****************************************
    sap_sense u_sense (
        .clk(clk),
        .resetn(resetn),
        .start(sense_start),
        .array_rdata(array_rdata),
        .busy(sense_busy),
        .done(sense_done),
        .rdata(sense_data)
    );

    // ****************************************
    // Write completion on write-enable rise
    // ****************************************
    // Independent of the bus clock; needs a latched lower half
    always_comb
    begin
        nxt_wr = 1'b0;
        nxt_wdata = wdata_ff;
        if (pin_s.write_en_n && !pin_prev_ff.write_en_n &&
            !pin_s.chip_en_n &&
            (state_ff == SAP_SENSE || state_ff == SAP_DATA))
        begin
            nxt_wr = 1'b1;
            nxt_wdata = adq_s;
        end
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_ff <= 1'b0;
            wdata_ff <= '0;
        end
        else
        begin
            wr_ff <= nxt_wr;
            wdata_ff <= nxt_wdata;
        end
    end
    assign array_wr = wr_ff;
    assign array_wdata = wdata_ff;

    // ****************************************
    // Data lines and ready/hold indicator
    // ****************************************
    // Not driven in the upper phase: the host still owns the bus there
    always_comb
    begin
        drive = !pin_s.chip_en_n && !pin_s.out_en_n &&
            pin_s.write_en_n &&
            (state_ff == SAP_SENSE || state_ff == SAP_DATA);
        // Early timing shows ready one cycle ahead, on sense done
        ready_lvl = state_ff == SAP_DATA ||
            (rcr_ff[BIT_TIM] && sense_done);
        adq_out = sense_data;
        adq_oe = drive;
        ready_oe = split_en ? drive : !pin_s.chip_en_n;
        ready_out = rcr_ff[BIT_POL] ? !ready_lvl : ready_lvl;
    end

    // ****************************************
    // Register port
    // ****************************************
    always_comb
    begin
        nxt_rcr = rcr_ff;
        nxt_rdata = 16'h0000;
        if (reg_wr && reg_addr == OFF_RCR)
            nxt_rcr = reg_wdata;
        if (reg_rd)
        begin
            case (reg_addr)
                OFF_RCR: nxt_rdata = rcr_ff;
                OFF_UPPER: nxt_rdata = 16'(upper_ff);
                OFF_LOWER: nxt_rdata = lower_ff;
                OFF_STATUS: nxt_rdata = {12'h000, state_ff,
                    sense_busy, viol_ff};
                default: nxt_rdata = 16'h0000;
            endcase
        end
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rcr_ff <= RCR_RESET;
            rdata_ff <= 16'h0000;
        end
        else
        begin
            rcr_ff <= nxt_rcr;
            rdata_ff <= nxt_rdata;
        end
    end
    assign reg_rdata = rdata_ff;

    // ****************************************
    // Assertions
    // ****************************************
    property p_upper_cap;
        @(posedge clk) disable iff (!resetn)
        cap_up |=> upper_ff == $past(adq_s[UP_W-1:0]);
    endproperty
    a_upper_cap: assert property (p_upper_cap)
        else $error("upper half not captured");
    property p_single_cycle;
        @(posedge clk) disable iff (!resetn)
        cap_lo && !reg_wr |=> array_addr ==
            {$past(split_en) ? $past(upper_ff) : UPPER_RESET,
            $past(adq_s)};
    endproperty
    a_single_cycle: assert property (p_single_cycle)
        else $error("lower capture lost the held upper half");
    property p_upper_hold;
        @(posedge clk) disable iff (!resetn)
        !cap_up && !reg_wr |=> $stable(upper_ff);
    endproperty
    a_upper_hold: assert property (p_upper_hold)
        else $error("upper latch changed without a new phase");
    property p_split_clear;
        @(posedge clk) disable iff (!resetn)
        reg_wr && reg_addr == OFF_RCR && reg_wdata[BIT_SPLIT] &&
            !split_en |=> split_en && upper_ff == UPPER_RESET;
    endproperty
    a_split_clear: assert property (p_split_clear)
        else $error("split entry did not clear upper latch");
    property p_boot_zero;
        @(posedge clk) disable iff (!resetn)
        !split_en |-> array_addr[UP_W+LO_W-1:LO_W] == UPPER_RESET;
    endproperty
    a_boot_zero: assert property (p_boot_zero)
        else $error("upper address nonzero outside split mode");
    property p_access;
        @(posedge clk) disable iff (!resetn)
        sense_start ##1 !sense_start |=> sense_done;
    endproperty
    a_access: assert property (p_access)
        else $error("access time exceeded");
    property p_indicator_oe;
        @(posedge clk) disable iff (!resetn)
        split_en |-> ready_oe == adq_oe;
    endproperty
    a_indicator_oe: assert property (p_indicator_oe)
        else $error("indicator drive differs from data drive");
    property p_polarity;
        @(posedge clk) disable iff (!resetn)
        state_ff == SAP_DATA |-> ready_out == !rcr_ff[BIT_POL];
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("indicator level wrong for polarity");
    property p_write_done;
        @(posedge clk) disable iff (!resetn)
        nxt_wr |=> array_wr && array_wdata == $past(adq_s);
    endproperty
    a_write_done: assert property (p_write_done)
        else $error("write not completed on write-enable rise");
    property p_restart;
        @(posedge clk) disable iff (!resetn)
        state_ff == SAP_SENSE && cap_lo && restart_ff |=> viol_ff;
    endproperty
    a_restart: assert property (p_restart)
        else $error("second early restart not flagged");
    property p_sync_start;
        @(posedge clk) disable iff (!resetn)
        cap_lo |=> sense_busy;
    endproperty
    a_sync_start: assert property (p_sync_start)
        else $error("lower capture did not start sensing");
    c_two_phase: cover property (@(posedge clk) disable iff (!resetn)
        cap_up ##1 cap_lo);
    c_sync_burst: cover property (@(posedge clk) disable iff (!resetn)
        burst_step && wl_end);
    c_write: cover property (@(posedge clk) disable iff (!resetn)
        array_wr && split_en);
endmodule
`default_nettype wire

// ### verilog/sap_sense.sv
/*
 * Array sense timer: fixed access count from start to data valid.
 * Assumes the array read data settle within the access count.
 */
`timescale 1ns/10ps
`default_nettype none
module sap_sense (
    input wire logic clk,
    input wire logic resetn,
    input wire logic start,
    input wire logic [sap_pkg::LO_W-1:0] array_rdata,
    output logic busy,
    output logic done,
    output logic [sap_pkg::LO_W-1:0] rdata
);
    import sap_pkg::*;
    localparam int unsigned CW = $clog2(ACCESS_CYC + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(ACCESS_CYC);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic busy_ff;
    logic nxt_busy;
    logic done_ff;
    logic nxt_done;
    logic [LO_W-1:0] data_ff;
    logic [LO_W-1:0] nxt_data;

    // ****************************************
    // Timer; a new start restarts the count
    // ****************************************
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_busy = busy_ff;
        nxt_done = 1'b0;
        nxt_data = data_ff;
        if (start)
        begin
            nxt_cnt = CW'(1);
            nxt_busy = 1'b1;
        end
        else if (busy_ff && cnt_ff == CNT_LAST)
        begin
            nxt_busy = 1'b0;
            nxt_done = 1'b1;
            nxt_data = array_rdata;
        end
        else if (busy_ff)
        begin
            nxt_cnt = cnt_ff + CW'(1);
        end
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
            data_ff <= '0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            busy_ff <= nxt_busy;
            done_ff <= nxt_done;
            data_ff <= nxt_data;
        end
    end
    assign busy = busy_ff;
    assign done = done_ff;
    assign rdata = data_ff;
endmodule
`default_nettype wire

// ### verilog/sap_sync.sv
/*
 * Two-flop synchroniser, one chain per bit.
 * Assumes inputs are quasi-static for at least two clocks where
 * several bits must be seen together.
 */
`timescale 1ns/10ps
`default_nettype none
module sap_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    input wire logic [W-1:0] rst_val,
    output logic [W-1:0] q
);
    import sap_pkg::*;
    genvar i;
    // ****************************************
    // Per-bit chains
    // ****************************************
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic meta_ff;
            logic sync_ff;
            logic nxt_meta;
            logic nxt_sync;
            // Only the second stage reads the first
            always_comb
            begin
                nxt_meta = d[i];
                nxt_sync = meta_ff;
            end
            // Reset to one keeps idle active-low pins inactive
            always_ff @(posedge clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    meta_ff <= 1'b1;
                    sync_ff <= 1'b1;
                end
                else
                begin
                    meta_ff <= nxt_meta;
                    sync_ff <= nxt_sync;
                end
            end
            assign q[i] = sync_ff;
        end
    endgenerate
endmodule
`default_nettype wire
